// >>> verilog/area0_access_timing.sv
// Area 0 static access timing controller with AHB-Lite register slave.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// What this block and the software that programs it do
// RULE1 - Software programs the bus control register before the wait control register.
// RULE2 - Software finishes wait configuration before accessing the area.
// RULE3 - Wait register layout applies only to the memory kinds served here.
// RULE4 - Wait register bits 31:13 and 5:2 always read as zero.
// RULE5 - Setup field 12:11 delays strobes 0.5 to 3.5 bus cycles after select.
// RULE6 - Wait field 10:7 inserts 0-6, 8, 10, 12, 14, 18 or 24 cycles.
// RULE7 - Software never writes wait codes 1101, 1110 or 1111.
// RULE8 - Wait field resets to 1010; setup, hold and mask reset to zero.
// RULE9 - Mask bit 6: zero honours external wait, one ignores it.
// RULE10 - Mask setting also applies when the wait count is zero.
// RULE11 - Hold field 1:0 delays select negation 0.5 to 3.5 cycles after strobes.
// RULE12 - Memory kind 0000 is normal space, 0011 byte-selection SRAM.
// RULE13 - Honoured external wait at wait end stretches strobes until released.
//////////////////////////////////////////////////////////////////////////////
module area0_access_timing
    import area0_timing_pkg::*;
#(
    parameter int ADDR_W = 21,
    parameter int DATA_W = 16
)(
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata,
    input wire logic i_acc_req,
    input wire logic i_acc_write,
    input wire logic [ADDR_W-1:0] i_acc_addr,
    input wire logic [DATA_W-1:0] i_acc_wdata,
    input wire logic [DATA_W/8-1:0] i_acc_be,
    output logic o_acc_done,
    output logic o_acc_err,
    output logic [DATA_W-1:0] o_acc_rdata,
    output logic [ADDR_W-1:0] o_ext_addr,
    output logic o_chip_select_n,
    output logic o_read_n,
    output logic [DATA_W/8-1:0] o_byte_lane_strobe_n,
    output logic [DATA_W-1:0] o_ext_data_out,
    output logic o_ext_data_oe,
    input wire logic [DATA_W-1:0] i_ext_data_in,
    input wire logic i_ext_wait_n
);

    localparam int LANES = DATA_W / 8;

    // Byte lanes must be whole, data at most 32 bits, and the address must fit a 32-bit word.
    if (DATA_W < 8 || DATA_W % 8 != 0 || DATA_W > 32 || ADDR_W < 1 || ADDR_W > 32)
    begin : g_bad_param
        $error("area0_access_timing: unsupported DATA_W or ADDR_W");
    end

    //////////////////////////////////////////////////////////////////////////
    // Register slave.
    logic dp_wr_ff;
    logic [31:0] dp_addr_ff;
    logic [31:0] bcr_ff;
    logic [31:0] wcr_ff;
    logic [31:0] nxt_bcr;
    logic [31:0] nxt_wcr;
    logic [31:0] nxt_hrdata;
    wire addr_take = i_hsel && i_htrans[HTRANS_ACTIVE_BIT] && i_hready;
    wire wr_bcr = dp_wr_ff && dp_addr_ff == BCR_ADDR;
    wire wr_wcr = dp_wr_ff && dp_addr_ff == WCR_ADDR;
    wire [31:0] rd_addr = {i_haddr[31:2], 2'b00};

    // Writes land in the data phase; reserved bits are dropped so they read zero.
    assign nxt_bcr = wr_bcr ? (i_hwdata & BCR_MASK) : bcr_ff;
    assign nxt_wcr = wr_wcr ? (i_hwdata & WCR_MASK) : wcr_ff; // RULE4 RULE3
    // Reads look at the next values so a read right behind a write sees it.
    assign nxt_hrdata = !(addr_take && !i_hwrite) ? 32'h0000_0000 :
                        rd_addr == BCR_ADDR ? nxt_bcr :
                        rd_addr == WCR_ADDR ? nxt_wcr : 32'h0000_0000;

    // The slave never stalls and always answers OKAY; unmapped reads return zero.
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            dp_wr_ff <= 1'b0;
            dp_addr_ff <= 32'h0000_0000;
            bcr_ff <= BCR_RESET;
            wcr_ff <= WCR_RESET; // RULE8
            o_hrdata <= 32'h0000_0000;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end
        else
        begin
            dp_wr_ff <= addr_take && i_hwrite;
            dp_addr_ff <= {i_haddr[31:2], 2'b00};
            bcr_ff <= nxt_bcr;
            wcr_ff <= nxt_wcr;
            o_hrdata <= nxt_hrdata;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Timing decode, in core clocks (two per bus cycle, one per half cycle).
    wire [3:0] mem_kind = bcr_ff[KIND_LSB +: 4];
    wire kind_ok = mem_kind == KIND_NORMAL || mem_kind == KIND_BYTE_SRAM; // RULE12 RULE3
    wire [1:0] sw_code = wcr_ff[SW_LSB +: 2];
    wire [3:0] wr_code = wcr_ff[WR_LSB +: 4];
    wire [1:0] hw_code = wcr_ff[HW_LSB +: 2];
    // Setup and hold are N + 0.5 bus cycles: 2N + 1 core clocks.
    wire [5:0] setup_clks = CLKS_PER_BUS_CYC * {4'h0, sw_code} + HALF_CYC_CLKS; // RULE5
    wire [5:0] hold_clks = CLKS_PER_BUS_CYC * {4'h0, hw_code} + HALF_CYC_CLKS; // RULE11
    // Strobe width is one base bus cycle plus the programmed wait cycles.
    wire [5:0] strobe_clks = 6'((CLKS_PER_BUS_CYC * (wait_cycles(wr_code) + 6'h01))); // RULE6

    //////////////////////////////////////////////////////////////////////////
    // External access sequencer.
    acc_state_t state_ff;
    acc_state_t nxt_state;
    logic [5:0] cnt_ff;
    logic [5:0] nxt_cnt;
    logic [5:0] lat_strobe_ff;
    logic [5:0] lat_hold_ff;
    logic lat_mask_ff;
    logic lat_write_ff;
    logic [LANES-1:0] lat_be_ff;
    wire cnt_zero = cnt_ff == 6'h00;
    wire start = state_ff == ST_IDLE && i_acc_req && kind_ok;
    wire refuse = state_ff == ST_IDLE && i_acc_req && !kind_ok;
    // The mask is applied even with zero waits: only the strobe end is checked.
    wire ext_stall = !lat_mask_ff && !i_ext_wait_n; // RULE9 RULE10
    wire strobe_end = state_ff == ST_STROBE && cnt_zero && !ext_stall; // RULE13
    wire strobe_begin = state_ff == ST_SETUP && cnt_zero;
    wire select_end = state_ff == ST_HOLD && cnt_zero;

    // Next state and counter; timings are frozen at start so a late register
    // write cannot corrupt an access already on the pins.
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        unique case (state_ff)
            ST_IDLE:
            begin
                if (start)
                begin
                    nxt_state = ST_SETUP;
                    nxt_cnt = setup_clks - 6'h01; // RULE5
                end
            end
            ST_SETUP:
            begin
                nxt_cnt = cnt_zero ? lat_strobe_ff - 6'h01 : cnt_ff - 6'h01;
                if (cnt_zero)
                    nxt_state = ST_STROBE;
            end
            ST_STROBE:
            begin
                // Count held at zero while the external wait stretches the strobe.
                if (strobe_end)
                begin
                    nxt_state = ST_HOLD;
                    nxt_cnt = lat_hold_ff - 6'h01; // RULE11
                end
                else if (!cnt_zero)
                    nxt_cnt = cnt_ff - 6'h01;
            end
            ST_HOLD:
            begin
                nxt_cnt = cnt_zero ? 6'h00 : cnt_ff - 6'h01;
                if (cnt_zero)
                    nxt_state = ST_IDLE;
            end
        endcase
    end

    // Sequencer registers and latched access parameters.
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            state_ff <= ST_IDLE;
            cnt_ff <= 6'h00;
            lat_strobe_ff <= 6'h02;
            lat_hold_ff <= 6'h01;
            lat_mask_ff <= 1'b0;
            lat_write_ff <= 1'b0;
            lat_be_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            if (start)
            begin
                lat_strobe_ff <= strobe_clks;
                lat_hold_ff <= hold_clks;
                lat_mask_ff <= wcr_ff[MASK_BIT]; // RULE9
                lat_write_ff <= i_acc_write;
                lat_be_ff <= i_acc_be;
            end
        end
    end

    // Pin and completion outputs, every one straight from a flip-flop.
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_ext_addr <= '0;
            o_chip_select_n <= 1'b1;
            o_read_n <= 1'b1;
            o_byte_lane_strobe_n <= '1;
            o_ext_data_out <= '0;
            o_ext_data_oe <= 1'b0;
            o_acc_done <= 1'b0;
            o_acc_err <= 1'b0;
            o_acc_rdata <= '0;
        end
        else
        begin
            o_acc_done <= select_end || refuse;
            o_acc_err <= refuse; // RULE3
            if (start)
            begin
                o_ext_addr <= i_acc_addr;
                o_ext_data_out <= i_acc_wdata;
                o_ext_data_oe <= i_acc_write;
                o_chip_select_n <= 1'b0;
            end
            if (strobe_begin)
            begin
                o_read_n <= lat_write_ff;
                o_byte_lane_strobe_n <= lat_write_ff ? ~lat_be_ff : '1;
            end
            if (strobe_end)
            begin
                o_read_n <= 1'b1;
                o_byte_lane_strobe_n <= '1;
                o_acc_rdata <= lat_write_ff ? o_acc_rdata : i_ext_data_in;
            end
            if (select_end)
            begin
                o_chip_select_n <= 1'b1;
                o_ext_data_oe <= 1'b0;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Checks: helper counters measure pin timing independently of the sequencer.
    logic [5:0] since_cs_ff;
    logic [5:0] since_stb_ff;
    logic [5:0] since_off_ff;
    logic wcr_written_ff;
    logic rd_wcr_ff;
    wire stb_on = !o_read_n || !(&o_byte_lane_strobe_n);

    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            since_cs_ff <= 6'h00;
            since_stb_ff <= 6'h00;
            since_off_ff <= 6'h00;
            wcr_written_ff <= 1'b0;
            rd_wcr_ff <= 1'b0;
        end
        else
        begin
            since_cs_ff <= o_chip_select_n ? 6'h00 : since_cs_ff + 6'h01;
            since_stb_ff <= stb_on ? since_stb_ff + 6'h01 : 6'h00;
            since_off_ff <= (o_chip_select_n || stb_on) ? 6'h00 : since_off_ff + 6'h01;
            wcr_written_ff <= wcr_written_ff || wr_wcr;
            rd_wcr_ff <= addr_take && !i_hwrite && rd_addr == WCR_ADDR;
        end
    end

    a_setup_delay: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE5
        $rose(stb_on) |-> since_cs_ff == setup_clks)
        else $error("Strobe did not follow select by the setup delay.");
    a_strobe_width: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE6
        $fell(stb_on) && $past(lat_mask_ff) |-> $past(since_stb_ff) + 6'h01 == lat_strobe_ff)
        else $error("Masked strobe width differs from the wait setting.");
    a_hold_delay: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE11
        $rose(o_chip_select_n) |-> $past(since_off_ff) + 6'h01 == lat_hold_ff)
        else $error("Select negation did not follow strobe by the hold delay.");
    a_reserved_zero: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE4
        rd_wcr_ff |-> (o_hrdata & ~WCR_MASK) == 32'h0000_0000)
        else $error("Reserved wait register bits read nonzero.");
    a_wait_reset_val: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE8
        !wcr_written_ff |-> wcr_ff == WCR_RESET)
        else $error("Wait register left its reset value unwritten.");
    a_ext_wait_held: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE13
        state_ff == ST_STROBE && cnt_zero && ext_stall |=> stb_on)
        else $error("Strobe ended while external wait was honoured.");
    a_wait_masked: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE9
        state_ff == ST_STROBE && cnt_zero && lat_mask_ff |=> !stb_on)
        else $error("Masked external wait stretched the strobe.");
    a_zero_wait_honour: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE10
        $rose(stb_on) && lat_strobe_ff == CLKS_PER_BUS_CYC && !lat_mask_ff && !i_ext_wait_n
        ##1 !i_ext_wait_n |=> stb_on)
        else $error("Zero-wait access ignored an honoured external wait.");
    a_kind_refuse: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // RULE12
        refuse |=> o_acc_err && o_acc_done && o_chip_select_n ##1 !o_acc_done)
        else $error("Unsupported memory kind was not refused.");

    c_stretched: cover property (@(posedge i_core_clk) disable iff (i_sys_rst)
        state_ff == ST_STROBE && cnt_zero && ext_stall);
    c_zero_wait_done: cover property (@(posedge i_core_clk) disable iff (i_sys_rst)
        select_end && lat_strobe_ff == CLKS_PER_BUS_CYC);
    c_refused: cover property (@(posedge i_core_clk) disable iff (i_sys_rst) refuse);

endmodule

// >>> verilog/area0_timing_pkg.sv
// Shared constants, register map and types for the area 0 static access timing block.
package area0_timing_pkg;

    // Register byte addresses on the AHB-Lite slave.
    localparam logic [31:0] BCR_ADDR = 32'h0000_0000;
    localparam logic [31:0] WCR_ADDR = 32'h0000_0004;

    // Area bus control register: only the memory kind field is kept.
    localparam logic [31:0] BCR_RESET = 32'h0000_0000;
    localparam logic [31:0] BCR_MASK = 32'h0000_f000;
    localparam int KIND_LSB = 12;
    localparam logic [3:0] KIND_NORMAL = 4'h0;
    localparam logic [3:0] KIND_BYTE_SRAM = 4'h3;

    // Area wait control register layout for normal space and byte-selection SRAM.
    localparam logic [31:0] WCR_RESET = 32'h0000_0500;
    localparam logic [31:0] WCR_MASK = 32'h0000_1fc3;
    localparam int SW_LSB = 11;
    localparam int WR_LSB = 7;
    localparam int MASK_BIT = 6;
    localparam int HW_LSB = 0;

    // One external bus cycle spans two core clocks, so a half cycle is one clock.
    localparam logic [5:0] CLKS_PER_BUS_CYC = 6'h02;
    localparam logic [5:0] HALF_CYC_CLKS = 6'h01;

    // AHB-Lite transfer type bit that marks an active transfer.
    localparam int HTRANS_ACTIVE_BIT = 1;

    typedef enum {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} acc_state_t;

    // Access wait code to wait cycles; prohibited codes fall back to zero.
    function automatic logic [5:0] wait_cycles(input logic [3:0] code);
        logic [5:0] cyc;
        cyc = 6'h00;
        unique case (code)
            4'h7: cyc = 6'h08;
            4'h8: cyc = 6'h0a;
            4'h9: cyc = 6'h0c;
            4'ha: cyc = 6'h0e;
            4'hb: cyc = 6'h12;
            4'hc: cyc = 6'h18;
            4'hd, 4'he, 4'hf: cyc = 6'h00;
            default: cyc = {2'h0, code};
        endcase
        return cyc;
    endfunction

endpackage

// >>> tb/ext_sram_model.sv
// Behavioural external static memory that can stretch a strobe with its wait line.
`timescale 1ns/1ps
module ext_sram_model (
    input wire logic i_core_clk,
    input wire logic [20:0] i_addr,
    input wire logic i_cs_n,
    input wire logic i_read_n,
    input wire logic [1:0] i_be_n,
    input wire logic [15:0] i_data,
    input wire logic [3:0] i_stall,
    output logic [15:0] o_data,
    output logic o_wait_n
);
    logic [15:0] mem_ff [16];
    logic [15:0] last_ff = 16'h0000;
    logic [3:0] cnt_ff = 4'h0;
    wire strobe_on = !i_cs_n && (!i_read_n || i_be_n != 2'h3);
    //////////////////////////////////////////////////////////////////////////////
    // Outside a read strobe the bus toggles, so a stale capture cannot pass.
    assign o_data = (!i_cs_n && !i_read_n) ? mem_ff[i_addr[3:0]] : ~last_ff;
    initial o_wait_n = 1'b1;
    // Wait goes low one clock into the strobe and is held for i_stall clocks; lanes write while strobed.
    always @(posedge i_core_clk)
    begin
        last_ff <= o_data;
        cnt_ff <= strobe_on ? cnt_ff + 4'h1 : 4'h0;
        o_wait_n <= !(strobe_on && cnt_ff < i_stall);
        if (!i_cs_n && !i_be_n[0])
            mem_ff[i_addr[3:0]][7:0] <= i_data[7:0];
        if (!i_cs_n && !i_be_n[1])
            mem_ff[i_addr[3:0]][15:8] <= i_data[15:8];
    end
endmodule

// >>> tb/test_area0_access_timing.sv
// Self-checking bench for the area 0 static access timing block.
`timescale 1ns/1ps
module test_area0_access_timing;
    import area0_timing_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, acc_done, acc_err, cs_n, read_n, oe, wait_n;
    logic [31:0] hrdata;
    logic acc_req = 1'b0;
    logic acc_write = 1'b0;
    logic [20:0] acc_addr = 21'h0;
    logic [15:0] acc_wdata = 16'h0;
    logic [1:0] be_n;
    logic [20:0] ext_addr;
    logic [15:0] acc_rdata, dout, din;
    logic [3:0] stall = 4'h0;
    int err_count = 0;
    int n_tests = 0;
    int cycles = 0;
    int waits[13] = '{0, 1, 2, 3, 4, 5, 6, 8, 10, 12, 14, 18, 24};
    //////////////////////////////////////////////////////////////////////////////
    area0_access_timing dut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
        .i_hwdata(hwdata), .i_hready(hreadyout), .o_hreadyout(hreadyout), .o_hresp(hresp),
        .o_hrdata(hrdata), .i_acc_req(acc_req), .i_acc_write(acc_write),
        .i_acc_addr(acc_addr), .i_acc_wdata(acc_wdata), .i_acc_be(2'h3),
        .o_acc_done(acc_done), .o_acc_err(acc_err), .o_acc_rdata(acc_rdata),
        .o_ext_addr(ext_addr), .o_chip_select_n(cs_n), .o_read_n(read_n),
        .o_byte_lane_strobe_n(be_n), .o_ext_data_out(dout), .o_ext_data_oe(oe),
        .i_ext_data_in(din), .i_ext_wait_n(wait_n));
    ext_sram_model mem (.i_core_clk(i_core_clk), .i_addr(ext_addr), .i_cs_n(cs_n),
        .i_read_n(read_n), .i_be_n(be_n), .i_data(dout), .i_stall(stall), .o_data(din),
        .o_wait_n(wait_n));
    //////////////////////////////////////////////////////////////////////////////
    initial forever #50 i_core_clk = ~i_core_clk;
    // The request is dropped in the done cycle so the idle state never restarts.
    always @(posedge acc_done) acc_req <= 1'b0;
    // A hung handshake ends the run here rather than spinning forever.
    always @(posedge i_core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            final_report();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One single AHB-Lite word transfer; read data is taken at the data phase edge.
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        @(posedge i_core_clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge i_core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge i_core_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // One access; clocks are sorted into setup, strobe and hold by the pin levels.
    task automatic acc(input logic wr, input logic [20:0] a, input logic [15:0] d,
        output int s, output int w, output int h, output logic [15:0] rd, output logic er);
        s = 0;
        w = 0;
        h = 0;
        @(posedge i_core_clk);
        acc_req <= 1'b1;
        acc_write <= wr;
        acc_addr <= a;
        acc_wdata <= d;
        for (int k = 0; k < 200; k++)
        begin
            @(negedge i_core_clk);
            if (acc_done === 1'b1)
                break;
            if (read_n === 1'b0 || be_n !== 2'h3)
                w++;
            else if (cs_n === 1'b0 && w == 0)
                s++;
            else if (cs_n === 1'b0)
                h++;
        end
        er = acc_err;
        rd = acc_rdata;
    endtask
    //////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [31:0] v;
        int s, w, h;
        logic [15:0] rd;
        logic er;
        ahb(1'b0, BCR_ADDR, 32'h0, v);
        check("bcr reset", v, 32'h0);
        ahb(1'b0, WCR_ADDR, 32'h0, v);
        check("wcr reset", v, 32'h0000_0500);
        ahb(1'b0, 32'h0000_0008, 32'h0, v);
        check("unmapped", v, 32'h0);
        acc(1'b1, 21'h0, 16'h1234, s, w, h, rd, er);
        check("reset strobe", w, 30);
        check("reset setup", s, 1);
        check("reset hold", h, 1);
        ahb(1'b1, WCR_ADDR, 32'hffff_fe7f, v);
        ahb(1'b0, WCR_ADDR, 32'h0, v);
        check("reserved", v, 32'h0000_1e43);
    endtask
    task automatic t_kind();
        logic [31:0] v;
        int s, w, h;
        logic [15:0] rd;
        logic er;
        ahb(1'b1, BCR_ADDR, 32'h0000_3000, v);
        ahb(1'b0, BCR_ADDR, 32'h0, v);
        check("kind rw", v, 32'h0000_3000);
        acc(1'b0, 21'h0, 16'h0, s, w, h, rd, er);
        check("sram ok", er, 1'b0);
        check("sram data", rd, 16'h1234);
        ahb(1'b1, BCR_ADDR, 32'h0000_5000, v);
        acc(1'b0, 21'h0, 16'h0, s, w, h, rd, er);
        check("kind refused", er, 1'b1);
        check("refused pins", s + w + h, 0);
        ahb(1'b1, BCR_ADDR, 32'h0, v);
    endtask
    task automatic t_timing();
        logic [31:0] v;
        int s, w, h;
        logic [15:0] rd;
        logic er;
        for (int c = 0; c < 13; c++)
        begin
            v = {19'h0, 2'(c % 4), 4'(c), 1'b1, 4'h0, 2'((c + 1) % 4)};
            ahb(1'b1, WCR_ADDR, v, v);
            acc(1'b1, 21'(c), {8'h5a, 8'(c)}, s, w, h, rd, er);
            check("setup", s, 2 * (c % 4) + 1);
            check("wr strobe", w, 2 * (1 + waits[c]));
            check("hold", h, 2 * ((c + 1) % 4) + 1);
            acc(1'b0, 21'(c), 16'h0, s, w, h, rd, er);
            check("rd strobe", w, 2 * (1 + waits[c]));
            check("rdata", rd, {8'h5a, 8'(c)});
        end
    endtask
    task automatic t_wait();
        logic [31:0] v;
        int s, w, h;
        logic [15:0] rd;
        logic er;
        ahb(1'b1, WCR_ADDR, 32'h0, v);
        stall <= 4'h6;
        acc(1'b0, 21'h1, 16'h0, s, w, h, rd, er);
        check("wait stretch", w, 8);
        check("stretch data", rd, 16'h5a01);
        ahb(1'b1, WCR_ADDR, 32'h0000_0040, v);
        acc(1'b0, 21'h1, 16'h0, s, w, h, rd, er);
        check("wait ignored", w, 2);
        stall <= 4'h0;
    endtask
    //////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        t_regs();
        t_kind();
        t_timing();
        t_wait();
        final_report();
    end
endmodule
